//--- rtl/ocdsc_top.v
// Purpose: Primary opcode decode and execution state accounting
// Assumes: Cycle counts per instruction come from the sequencer's table
// Notes: Outputs registered; results valid one edge after the request
`timescale 1ns/100ps
`include "ocdsc_regs.vh"

module ocdsc_top (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire instr_valid_i,
  input wire [15:0] instr_word_i,
  input wire [15:0] instr_word2_i,
  input wire [`OCDSC_CNT_W-1:0] cnt_fetch_i,
  input wire [`OCDSC_CNT_W-1:0] cnt_vector_i,
  input wire [`OCDSC_CNT_W-1:0] cnt_stack_i,
  input wire [`OCDSC_CNT_W-1:0] cnt_byte_i,
  input wire [`OCDSC_CNT_W-1:0] cnt_word_i,
  input wire [`OCDSC_CNT_W-1:0] cnt_internal_i,
  input wire [1:0] loc_fetch_i,
  input wire [1:0] loc_vector_i,
  input wire [1:0] loc_stack_i,
  input wire [1:0] loc_data_i,
  input wire [`OCDSC_WAIT_W-1:0] wait_states_i,
  input wire [`OCDSC_COST_W-1:0] eclk_states_i,
  output reg result_valid_o,
  output reg [`OCDSC_GRP_W-1:0] group_o,
  output reg [7:0] primary_op_o,
  output reg split_bit_o,
  output reg [`OCDSC_CNT_W-1:0] cnt_fetch_o,
  output reg [`OCDSC_CNT_W-1:0] cnt_vector_o,
  output reg [`OCDSC_CNT_W-1:0] cnt_stack_o,
  output reg [`OCDSC_CNT_W-1:0] cnt_byte_o,
  output reg [`OCDSC_CNT_W-1:0] cnt_word_o,
  output reg [`OCDSC_CNT_W-1:0] cnt_internal_o,
  output reg [`OCDSC_TOT_W-1:0] exec_states_o
);

  // ****************************************
  // Decode
  // ****************************************
  wire [7:0] op_hi;
  wire split;
  reg [`OCDSC_GRP_W-1:0] grp_next;
  reg is_eclk;

  assign op_hi = instr_word_i[`OCDSC_OP_HI:`OCDSC_OP_LO];
  assign split = instr_word_i[`OCDSC_SPLIT_BIT];

  // Peripheral moves share bits 15..8 with moves, so bits 7..4 must decide
  function ep_match;
    input [15:0] word;
    input [3:0] code;
    begin
      ep_match = (word[`OCDSC_OP_HI:`OCDSC_OP_LO] == `OCDSC_OP_MOVD) &&
                 (word[`OCDSC_EP_SEL_HI:`OCDSC_EP_SEL_LO] == code);
    end
  endfunction

  always @* begin
    grp_next = `OCDSC_GRP_OTHER;
    is_eclk = 1'b0;
    case (op_hi[7:4])
      4'h0: begin
        grp_next = (op_hi == `OCDSC_OP_NOP) ? `OCDSC_GRP_NOP : `OCDSC_GRP_ARITH;
        if (op_hi[3:0] == 4'hc || op_hi[3:0] == 4'hd)
          grp_next = `OCDSC_GRP_MOVE;
      end
      4'h2, 4'h3, 4'hf: begin
        grp_next = `OCDSC_GRP_MOVE;
      end
      4'h4: begin
        // Aliases share machine code, so only the base names exist here
        case (op_hi)
          `OCDSC_OP_BRA: grp_next = `OCDSC_GRP_BRA;
          `OCDSC_OP_BRN: grp_next = `OCDSC_GRP_BRN;
          `OCDSC_OP_BCC: grp_next = `OCDSC_GRP_BCC;
          `OCDSC_OP_BCS: grp_next = `OCDSC_GRP_BCS;
          default: grp_next = `OCDSC_GRP_BCOND;
        endcase
      end
      4'h5: begin
        grp_next = `OCDSC_GRP_JUMP;
      end
      4'h6: begin
        grp_next = op_hi[3] ? `OCDSC_GRP_MOVE : `OCDSC_GRP_BIT;
        // Push and pop arrive here as plain moves
        if (op_hi[3]) grp_next = `OCDSC_GRP_MOVE;
        if (ep_match(instr_word_i, `OCDSC_EP_FROM)) begin
          grp_next = `OCDSC_GRP_EPMOVE_FROM;
          is_eclk = 1'b1;
        end
        if (ep_match(instr_word_i, `OCDSC_EP_TO)) begin
          grp_next = `OCDSC_GRP_EPMOVE_TO;
          is_eclk = 1'b1;
        end
      end
      4'h7: begin
        grp_next = (op_hi[3:0] >= 4'h8 && op_hi[3:0] <= 4'ha) ?
                   `OCDSC_GRP_MOVE : `OCDSC_GRP_BIT;
      end
      default: begin
        grp_next = `OCDSC_GRP_ARITH;
      end
    endcase
  end

  // ****************************************
  // State costs
  // ****************************************
  wire [`OCDSC_COST_W-1:0] s_fetch;
  wire [`OCDSC_COST_W-1:0] s_vector;
  wire [`OCDSC_COST_W-1:0] s_stack;
  wire [`OCDSC_COST_W-1:0] s_byte;
  wire [`OCDSC_COST_W-1:0] s_word;
  wire [`OCDSC_COST_W-1:0] s_internal;

  // Fetch and stack are word cycles; the bus reports its wait count
  ocdsc_cost u_cost_fetch (
    .loc_i(loc_fetch_i),
    .word_i(1'b1),
    .eclk_i(1'b0),
    .wait_i(wait_states_i),
    .eclk_states_i(eclk_states_i),
    .cost_o(s_fetch)
  );

  ocdsc_cost u_cost_vector (
    .loc_i(loc_vector_i),
    .word_i(1'b1),
    .eclk_i(1'b0),
    .wait_i(wait_states_i),
    .eclk_states_i(eclk_states_i),
    .cost_o(s_vector)
  );

  ocdsc_cost u_cost_stack (
    .loc_i(loc_stack_i),
    .word_i(1'b1),
    .eclk_i(1'b0),
    .wait_i(wait_states_i),
    .eclk_states_i(eclk_states_i),
    .cost_o(s_stack)
  );

  ocdsc_cost u_cost_byte (
    .loc_i(loc_data_i),
    .word_i(1'b0),
    .eclk_i(is_eclk),
    .wait_i(wait_states_i),
    .eclk_states_i(eclk_states_i),
    .cost_o(s_byte)
  );

  ocdsc_cost u_cost_word (
    .loc_i(loc_data_i),
    .word_i(1'b1),
    .eclk_i(1'b0),
    .wait_i(wait_states_i),
    .eclk_states_i(eclk_states_i),
    .cost_o(s_word)
  );

  // Internal operations never leave the core
  assign s_internal = `OCDSC_S_ONCHIP;

  function [`OCDSC_TOT_W-1:0] mul_cost;
    input [`OCDSC_CNT_W-1:0] cnt;
    input [`OCDSC_COST_W-1:0] cost;
    begin
      mul_cost = {{(`OCDSC_TOT_W-`OCDSC_CNT_W){1'b0}}, cnt} *
                 {{(`OCDSC_TOT_W-`OCDSC_COST_W){1'b0}}, cost};
    end
  endfunction

  wire [`OCDSC_TOT_W-1:0] total_next;

  assign total_next = mul_cost(cnt_fetch_i, s_fetch) + mul_cost(cnt_vector_i, s_vector) +
                      mul_cost(cnt_stack_i, s_stack) + mul_cost(cnt_byte_i, s_byte) +
                      mul_cost(cnt_word_i, s_word) +
                      mul_cost(cnt_internal_i, s_internal);

  // ****************************************
  // Output registers
  // ****************************************
  always @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      result_valid_o <= 1'b0;
      group_o <= `OCDSC_GRP_OTHER;
      primary_op_o <= 8'h00;
      split_bit_o <= 1'b0;
      cnt_fetch_o <= 4'h0;
      cnt_vector_o <= 4'h0;
      cnt_stack_o <= 4'h0;
      cnt_byte_o <= 4'h0;
      cnt_word_o <= 4'h0;
      cnt_internal_o <= 4'h0;
      exec_states_o <= 12'h000;
    end else begin
      result_valid_o <= instr_valid_i;
      if (instr_valid_i) begin
        group_o <= grp_next;
        primary_op_o <= op_hi;
        split_bit_o <= split;
        cnt_fetch_o <= cnt_fetch_i;
        cnt_vector_o <= cnt_vector_i;
        cnt_stack_o <= cnt_stack_i;
        cnt_byte_o <= cnt_byte_i;
        cnt_word_o <= cnt_word_i;
        cnt_internal_o <= cnt_internal_i;
        exec_states_o <= total_next;
      end
    end
  end

endmodule

//--- rtl/ocdsc_regs.vh
// Purpose: Constants for the opcode decoder and state accounting block
// Assumes: Included by bare name from rtl/
// Notes: Definitions only
`ifndef OCDSC_REGS_VH
`define OCDSC_REGS_VH

// ****************************************
// Opcode fields
// ****************************************
`define OCDSC_OP_HI 15
`define OCDSC_OP_LO 8
`define OCDSC_SPLIT_BIT 7

// ****************************************
// Decode groups
// ****************************************
`define OCDSC_GRP_W 5
`define OCDSC_GRP_OTHER 5'h00
`define OCDSC_GRP_MOVE 5'h01
`define OCDSC_GRP_EPMOVE_FROM 5'h02
`define OCDSC_GRP_EPMOVE_TO 5'h03
`define OCDSC_GRP_BRA 5'h04
`define OCDSC_GRP_BRN 5'h05
`define OCDSC_GRP_BCC 5'h06
`define OCDSC_GRP_BCS 5'h07
`define OCDSC_GRP_BCOND 5'h08
`define OCDSC_GRP_ARITH 5'h09
`define OCDSC_GRP_BIT 5'h0a
`define OCDSC_GRP_JUMP 5'h0b
`define OCDSC_GRP_NOP 5'h0c

// ****************************************
// Primary opcodes
// ****************************************
`define OCDSC_OP_NOP 8'h00
`define OCDSC_OP_BRA 8'h40
`define OCDSC_OP_BRN 8'h41
`define OCDSC_OP_BCC 8'h44
`define OCDSC_OP_BCS 8'h45
`define OCDSC_OP_MOVD 8'h6a
`define OCDSC_EP_SEL_HI 7
`define OCDSC_EP_SEL_LO 4
`define OCDSC_EP_FROM 4'h4
`define OCDSC_EP_TO 4'hc

// ****************************************
// Per-cycle state costs
// ****************************************
`define OCDSC_CNT_W 4
`define OCDSC_WAIT_W 4
`define OCDSC_COST_W 8
`define OCDSC_TOT_W 12
`define OCDSC_S_ONCHIP 8'h02
`define OCDSC_S_REG_BYTE 8'h03
`define OCDSC_S_REG_WORD 8'h06
`define OCDSC_S_EXT_BYTE 8'h03
`define OCDSC_S_EXT_WORD 8'h06
`define OCDSC_S_ECLK_MIN 8'h09
`define OCDSC_S_ECLK_MAX 8'h10

// Access location codes
`define OCDSC_LOC_ONCHIP 2'h0
`define OCDSC_LOC_REG 2'h1
`define OCDSC_LOC_EXT 2'h2

`endif

//--- rtl/ocdsc_cost.v
// Purpose: States taken by one cycle of a given type and location
// Assumes: Wait count valid for external cycles only
// Notes: Purely combinational
`timescale 1ns/100ps
`include "ocdsc_regs.vh"

module ocdsc_cost (
  input wire [1:0] loc_i,
  input wire word_i,
  input wire eclk_i,
  input wire [`OCDSC_WAIT_W-1:0] wait_i,
  input wire [`OCDSC_COST_W-1:0] eclk_states_i,
  output reg [`OCDSC_COST_W-1:0] cost_o
);

  wire [`OCDSC_COST_W-1:0] wait_ext;

  assign wait_ext = {{(`OCDSC_COST_W-`OCDSC_WAIT_W){1'b0}}, wait_i};

  always @* begin
    cost_o = `OCDSC_S_ONCHIP;
    case (loc_i)
      `OCDSC_LOC_REG: begin
        cost_o = word_i ? `OCDSC_S_REG_WORD : `OCDSC_S_REG_BYTE;
      end
      `OCDSC_LOC_EXT: begin
        if (eclk_i && !word_i) begin
          // Clamp so a bad alignment report cannot leave the legal window
          if (eclk_states_i < `OCDSC_S_ECLK_MIN)
            cost_o = `OCDSC_S_ECLK_MIN;
          else if (eclk_states_i > `OCDSC_S_ECLK_MAX)
            cost_o = `OCDSC_S_ECLK_MAX;
          else
            cost_o = eclk_states_i;
        end else if (word_i) begin
          cost_o = `OCDSC_S_EXT_WORD + (wait_ext << 1);
        end else begin
          cost_o = `OCDSC_S_EXT_BYTE + wait_ext;
        end
      end
      default: begin
        cost_o = `OCDSC_S_ONCHIP;
      end
    endcase
  end

endmodule

//--- tb/ocdsc_mem_model.sv
// Purpose: Memory bus side of the core, reports wait states per cycle
// Assumes: Bench chooses a prompt or a slow memory
// Notes: E clock phase free-runs, so peripheral byte cost wanders 9..16
`timescale 1ns/100ps
module ocdsc_mem_model (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire slow_i,
  output reg [3:0] wait_states_o,
  output reg [7:0] eclk_states_o
);
  reg [2:0] phase_reg;
  always @(negedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i)
      phase_reg <= 3'h0;
    else
      phase_reg <= phase_reg + 3'h1;
  end
  always @* begin
    wait_states_o = slow_i ? 4'h1 : 4'h0;
    eclk_states_o = 8'h09 + {5'h0, phase_reg};
  end
endmodule

//--- tb/ocdsc_asserts.sv
// Purpose: Port checks for the decoder and state totals
// Assumes: One clock, asynchronous active low reset
// Notes: Bound to ocdsc_top below
`timescale 1ns/100ps
`include "ocdsc_regs.vh"
module ocdsc_asserts (
  input wire sys_clk_i,
  input wire rst_b_i,
  input wire instr_valid_i,
  input wire [15:0] instr_word_i,
  input wire [3:0] cnt_fetch_i,
  input wire [3:0] cnt_vector_i,
  input wire [3:0] cnt_stack_i,
  input wire [3:0] cnt_byte_i,
  input wire [3:0] cnt_word_i,
  input wire [3:0] cnt_internal_i,
  input wire [1:0] loc_data_i,
  input wire [3:0] wait_states_i,
  input wire result_valid_o,
  input wire [4:0] group_o,
  input wire [7:0] primary_op_o,
  input wire split_bit_o,
  input wire [11:0] exec_states_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Single-type cases give exact totals without a full model
  wire [11:0] no_jkm = {cnt_vector_i, cnt_stack_i, cnt_word_i};
  wire only_int = no_jkm == 12'h0 && cnt_fetch_i == 4'h0 && cnt_byte_i == 4'h0;
  wire only_byte = no_jkm == 12'h0 && cnt_fetch_i == 4'h0 && cnt_internal_i == 4'h0;
  wire only_word = {cnt_fetch_i, cnt_vector_i, cnt_stack_i, cnt_byte_i, cnt_internal_i} == 20'h0;
  property p_ans; instr_valid_i |=> result_valid_o; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_quiet; !instr_valid_i |=> !result_valid_o && $stable(exec_states_o); endproperty
  a_quiet: assert property (p_quiet) else $error("output moved");
  property p_op; instr_valid_i |=> primary_op_o == $past(instr_word_i[15:8]); endproperty
  a_op: assert property (p_op) else $error("bad first byte");
  property p_split; instr_valid_i |=> split_bit_o == $past(instr_word_i[7]); endproperty
  a_split: assert property (p_split) else $error("bad split bit");
  property p_alias; instr_valid_i && instr_word_i[15:8] == 8'h44 |=> group_o == 5'h06; endproperty
  a_alias: assert property (p_alias) else $error("alias not carry clear");
  property p_ep; instr_valid_i && instr_word_i[15:4] == 12'h6ac |=> group_o == 5'h03; endproperty
  a_ep: assert property (p_ep) else $error("peripheral move missed");
  property p_ep_from; instr_valid_i && instr_word_i[15:4] == 12'h6a4 |=> group_o == 5'h02;
  endproperty
  a_ep_from: assert property (p_ep_from) else $error("peripheral read missed");
  property p_push; instr_valid_i && instr_word_i[15:8] == 8'h6d |=> group_o == 5'h01;
  endproperty
  a_push: assert property (p_push) else $error("stack move not a move");
  property p_int; instr_valid_i && only_int |=> exec_states_o == 2 * $past(cnt_internal_i);
  endproperty
  a_int: assert property (p_int) else $error("internal total");
  property p_regb; instr_valid_i && only_byte && loc_data_i == 2'h1
    |=> exec_states_o == 3 * $past(cnt_byte_i); endproperty
  a_regb: assert property (p_regb) else $error("register byte total");
  property p_extw; instr_valid_i && only_word && loc_data_i == 2'h2
    |=> exec_states_o == $past(cnt_word_i) * (6 + 2 * $past(wait_states_i)); endproperty
  a_extw: assert property (p_extw) else $error("external word total");
  c_ep: cover property (instr_valid_i && instr_word_i[15:4] == 12'h6a4);
  c_b2b: cover property (instr_valid_i [*3]);
  c_slow: cover property (result_valid_o && wait_states_i != 4'h0);
endmodule
bind ocdsc_top ocdsc_asserts u_chk (
  .sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i),
  .instr_valid_i(instr_valid_i),
  .instr_word_i(instr_word_i),
  .cnt_fetch_i(cnt_fetch_i),
  .cnt_vector_i(cnt_vector_i),
  .cnt_stack_i(cnt_stack_i),
  .cnt_byte_i(cnt_byte_i),
  .cnt_word_i(cnt_word_i),
  .cnt_internal_i(cnt_internal_i),
  .loc_data_i(loc_data_i),
  .wait_states_i(wait_states_i),
  .result_valid_o(result_valid_o),
  .group_o(group_o),
  .primary_op_o(primary_op_o),
  .split_bit_o(split_bit_o),
  .exec_states_o(exec_states_o)
);

//--- tb/opcode_decode_and_state_count_tb.sv
// Purpose: Self-checking bench for ocdsc_top
// Assumes: Inputs change on the falling edge
// Notes: Totals are worked out here from the per-cycle costs
`timescale 1ns/100ps
`include "ocdsc_regs.vh"
module opcode_decode_and_state_count_tb;
  reg clk, rst_b, vld, slow;
  reg [15:0] w;
  reg [23:0] c;
  reg [7:0] loc, e;
  reg [3:0] m;
  wire [3:0] ws, cf, cv, ck, cl, cm, cn;
  wire [7:0] es, pop;
  wire rv, sb;
  wire [4:0] grp;
  wire [11:0] tot;
  integer num_errors, n_compared, cyc, i;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ocdsc_mem_model mem (.sys_clk_i(clk), .rst_b_i(rst_b), .slow_i(slow), .wait_states_o(ws),
    .eclk_states_o(es));
  ocdsc_top DUT (.sys_clk_i(clk), .rst_b_i(rst_b), .instr_valid_i(vld), .instr_word_i(w),
    .instr_word2_i(~w), .cnt_fetch_i(c[23:20]), .cnt_vector_i(c[19:16]),
    .cnt_stack_i(c[15:12]), .cnt_byte_i(c[11:8]), .cnt_word_i(c[7:4]), .cnt_internal_i(c[3:0]),
    .loc_fetch_i(loc[7:6]), .loc_vector_i(loc[5:4]), .loc_stack_i(loc[3:2]),
    .loc_data_i(loc[1:0]), .wait_states_i(ws), .eclk_states_i(es), .result_valid_o(rv),
    .group_o(grp), .primary_op_o(pop), .split_bit_o(sb), .cnt_fetch_o(cf), .cnt_vector_o(cv),
    .cnt_stack_o(ck), .cnt_byte_o(cl), .cnt_word_o(cm), .cnt_internal_o(cn),
    .exec_states_o(tot));
  function [11:0] st(input [1:0] l, input wd, input [3:0] mm);
    st = l == 2'h2 ? (wd ? 12'h6 + 2 * mm : 12'h3 + mm) : l == 2'h1 ? (wd ? 12'h6 : 12'h3) : 12'h2;
  endfunction
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  // One request, held valid so calls run back to back
  task ex(input [15:0] wi, input [23:0] ci, input [7:0] li, input [4:0] g);
    reg [11:0] x;
    begin
      w = wi;
      c = ci;
      loc = li;
      vld = 1'b1;
      @(posedge clk);
      m = ws;
      e = es;
      @(negedge clk);
      x = ci[23:20] * st(li[7:6], 1'b1, m) + ci[19:16] * st(li[5:4], 1'b1, m)
        + ci[15:12] * st(li[3:2], 1'b1, m) + ci[7:4] * st(li[1:0], 1'b1, m) + ci[3:0] * 12'h2
        + ci[11:8] * ((g == 5'h02 || g == 5'h03) && li[1:0] == 2'h2 ? e : st(li[1:0], 1'b0, m));
      chk(rv, 12'h1);
      chk(pop, wi[15:8]);
      chk(sb, wi[7]);
      chk(grp, g);
      chk({cf, cv, cn}, {ci[23:16], ci[3:0]});
      chk({ck, cl, cm}, ci[15:4]);
      chk(tot, x);
    end
  endtask
  task t_alias;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        ex({8'h40, i[2], 7'h12} + {5'h0, i[1], 1'b0, i[0], 8'h0}, 24'h200000, 8'h0, 5'h04 + i[1:0]);
      end
      ex(16'h4612, 24'h200000, 8'h0, 5'h08);
    end
  endtask
  task t_move;
    begin
      slow = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        ex(16'h6a40, 24'h200100, 8'h02, 5'h02);
      end
      ex(16'h6ac0, 24'h200100, 8'h02, 5'h03);
      ex(16'h6a00, 24'h200100, 8'h02, 5'h01);
      ex(16'h6df7, 24'h100010, 8'h02, 5'h01);
      ex(16'h6d77, 24'h100010, 8'h02, 5'h01);
    end
  endtask
  task t_states;
    begin
      ex(16'h7d10, 24'h200200, 8'h81, 5'h0a);
      chk(tot, 12'h016);
      ex(16'h5e30, 24'h211000, 8'haa, 5'h0b);
      chk(tot, 12'h020);
      ex(16'h7d10, 24'h000300, 8'h01, 5'h0a);
      ex(16'h0c12, 24'h000020, 8'h02, 5'h01);
      ex(16'h0812, 24'h100020, 8'h01, 5'h09);
      slow = 1'b0;
      ex(16'h0000, 24'h00000f, 8'h0, 5'h0c);
      ex(16'h0c12, 24'h100010, 8'h02, 5'h01);
    end
  endtask
  task t_hold;
    begin
      vld = 1'b0;
      repeat (2) @(negedge clk);
      chk(rv, 12'h0);
      chk(tot, 12'h008);
      rst_b = 1'b0;
      @(negedge clk);
      chk({rv, grp, pop, sb, tot}, 27'h0);
      rst_b = 1'b1;
    end
  endtask
  task stop_test;
    begin
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      stop_test;
    end
  end
  initial begin
    rst_b = 1'b0;
    vld = 1'b0;
    slow = 1'b0;
    w = 16'h0;
    c = 24'h0;
    loc = 8'h0;
    num_errors = 0;
    n_compared = 0;
    cyc = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst_b = 1'b1;
    chk({rv, grp, pop, sb, tot}, 27'h0);
    chk({cf, cv, ck, cl, cm, cn}, 24'h0);
    t_alias;
    t_move;
    t_states;
    t_hold;
    ex(16'h4512, 24'h200000, 8'h0, 5'h07);
    stop_test;
  end
endmodule
